// ### design/adcc_pkg.sv
// Package for the converter control block: map, fields, resets, timing, types
package adcc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_CTRL   = 12'hf70;
  localparam logic [11:0] IDX_BUFALM = 12'hf71;
  localparam logic [11:0] IDX_RES_HI = 12'hf72;
  localparam logic [11:0] IDX_RES_LO = 12'hf73;
  localparam logic [11:0] IDX_THR_HI = 12'hf74;
  localparam logic [11:0] IDX_THR_LO = 12'hf76;
  localparam logic [11:0] IDX_POWER  = 12'hf7c;
  // Field positions
  localparam int CTRL_GO     = 7;
  localparam int CTRL_REFL   = 6;
  localparam int CTRL_REF_DRIVE_OUT = 5;
  localparam int CTRL_REPEAT = 4;
  localparam int BA_REFH     = 7;
  localparam int BA_HST      = 6;
  localparam int BA_LST      = 5;
  localparam int BA_HEN      = 4;
  localparam int BA_LEN      = 3;
  localparam int PWR_AUX_OFF = 0;
  localparam int PWR_ADC_EN  = 1;
  localparam int RES_W       = 13;
  // Reset values
  localparam logic [6:0] CTRL_RST   = 7'h00;
  localparam logic [7:0] BUFALM_RST = 8'h80;
  localparam logic [7:0] THR_HI_RST = 8'hff;
  localparam logic [7:0] THR_LO_RST = 8'h00;
  localparam logic [1:0] PWR_RST    = 2'h3;
  // Conversion timing in system clock cycles
  localparam int FIRST_CYCLES  = 5129;
  localparam int REPEAT_CYCLES = 256;
  // Input select codes
  localparam logic [3:0] SE_LAST   = 4'h7;
  localparam logic [3:0] SE_GND    = 4'hc;
  localparam logic [3:0] SE_TEMP   = 4'he;
  localparam logic [3:0] DIFF_LAST = 4'ha;
  localparam logic [3:0] DIFF_CAL  = 4'hf;
  // Reference select codes {high, low}
  localparam logic [1:0] REF_EXT = 2'h0;
  localparam logic [1:0] REF_1V0 = 2'h1;
  localparam logic [1:0] REF_2V0 = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_REPEAT} adcc_state_t;

  // Controls toward the analog core and switches
  typedef struct packed {
    logic       run;
    logic       restart;
    logic       switch_en;
    logic       diff;
    logic       buffered;
    logic       temp_sel;
    logic       gnd_amp;
    logic       offset_cal;
    logic [3:0] chan;
    logic       ref_int;
    logic       ref_2v0;
    logic       ref_drive;
    logic       aux_amp_on;
  } adcc_ana_t;

  // Sample from the analog core
  typedef struct packed {
    logic [12:0] data;
    logic        ovf;
  } adcc_smp_t;
endpackage

// ### design/adcc_top.sv
// Converter control: APB registers, conversion sequencing, alarms, result latch
`timescale 1ns/10ps
module adcc_top
  import adcc_pkg::*;
#(
  parameter int FIRST_CYC  = FIRST_CYCLES,
  parameter int REPEAT_CYC = REPEAT_CYCLES
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [13:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Analog core
  input  wire adcc_smp_t   SAMPLE,
  output adcc_ana_t        ANA,
  // Interrupt request pulse
  output logic             IRQ
);

  // Counts must fit the 16-bit counter after doubling
  if (FIRST_CYC < 2 || REPEAT_CYC < 2 || 2 * FIRST_CYC > 65535 || 2 * REPEAT_CYC > 65535) begin
    $error("adcc_top: conversion counts out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic [11:0] idx;
  logic        access;
  logic        wr;
  logic        rd;
  logic        aligned;
  logic        hit_ctrl;
  logic        hit_bufalm;
  logic        hit_res_hi;
  logic        hit_res_lo;
  logic        hit_thr_hi;
  logic        hit_thr_lo;
  logic        hit_power;
  logic        mapped;

  // Address and strobe decode
  assign idx        = PADDR[13:2];
  assign aligned    = (PADDR[1:0] == 2'h0);
  assign access     = PSEL & PENABLE;
  assign wr         = access & PWRITE;
  assign rd         = access & ~PWRITE;
  assign hit_ctrl   = aligned & (idx == IDX_CTRL);
  assign hit_bufalm = aligned & (idx == IDX_BUFALM);
  assign hit_res_hi = aligned & (idx == IDX_RES_HI);
  assign hit_res_lo = aligned & (idx == IDX_RES_LO);
  assign hit_thr_hi = aligned & (idx == IDX_THR_HI);
  assign hit_thr_lo = aligned & (idx == IDX_THR_LO);
  assign hit_power  = aligned & (idx == IDX_POWER);
  assign mapped     = hit_ctrl | hit_bufalm | hit_res_hi | hit_res_lo
                    | hit_thr_hi | hit_thr_lo | hit_power;
  assign PREADY     = 1'b1;
  assign PSLVERR    = access & ~mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  logic [6:0]  ctrl;      // ref low, ref drive, repeat, input select
  logic        ref_high;
  logic        upper_alarm_irq_enable;
  logic        lower_alarm_irq_enable;
  logic [2:0]  buffer_mode_field;
  logic [7:0]  upper_threshold;
  logic [7:0]  lower_threshold;
  logic [1:0]  power_control_zero;
  logic        go_write;
  logic        adc_en;

  assign go_write = wr & hit_ctrl & PWDATA[CTRL_GO];
  assign adc_en   = power_control_zero[PWR_ADC_EN];

  // Control register writes; result bytes have no write path
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ctrl                   <= CTRL_RST;
      ref_high               <= BUFALM_RST[BA_REFH];
      upper_alarm_irq_enable <= BUFALM_RST[BA_HEN];
      lower_alarm_irq_enable <= BUFALM_RST[BA_LEN];
      buffer_mode_field      <= BUFALM_RST[2:0];
      upper_threshold        <= THR_HI_RST;
      lower_threshold        <= THR_LO_RST;
      power_control_zero     <= PWR_RST;
    end else begin
      if (wr && hit_ctrl) begin
        ctrl <= PWDATA[6:0];
      end
      if (wr && hit_bufalm) begin
        ref_high               <= PWDATA[BA_REFH];
        upper_alarm_irq_enable <= PWDATA[BA_HEN];
        lower_alarm_irq_enable <= PWDATA[BA_LEN];
        buffer_mode_field      <= PWDATA[2:0];
      end
      if (wr && hit_thr_hi) begin
        upper_threshold <= PWDATA[7:0];
      end
      if (wr && hit_thr_lo) begin
        lower_threshold <= PWDATA[7:0];
      end
      if (wr && hit_power) begin
        power_control_zero <= PWDATA[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input and reference decode

  logic [3:0] input_select;
  logic       repeat_conversion;
  logic [1:0] ref_sel;
  logic       single_ended;
  logic       mode_ok;
  logic       code_ok;
  logic       temp_sel;

  // Field views and mode-dependent channel legality
  assign input_select      = ctrl[3:0];
  assign repeat_conversion = ctrl[CTRL_REPEAT];
  assign ref_sel           = {ref_high, ctrl[CTRL_REFL]};
  assign mode_ok           = ~buffer_mode_field[1];
  assign single_ended      = ~buffer_mode_field[2];
  assign code_ok = single_ended
                 ? (input_select <= SE_LAST) | (input_select == SE_GND)
                   | (input_select == SE_TEMP)
                 : (input_select <= DIFF_LAST) | (input_select == DIFF_CAL);
  assign temp_sel = mode_ok & single_ended & (input_select == SE_TEMP);

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer

  adcc_state_t state;
  adcc_state_t next_state;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic [15:0] first_lim;
  logic [15:0] rep_lim;
  logic        done;
  logic        busy;

  // Temperature input doubles both intervals
  assign first_lim = temp_sel ? 16'(2 * FIRST_CYC) : 16'(FIRST_CYC);
  assign rep_lim   = temp_sel ? 16'(2 * REPEAT_CYC) : 16'(REPEAT_CYC);
  assign busy      = (state != ST_IDLE);

  // Next state and cycle count
  always_comb begin
    next_state = state;
    next_cnt   = cnt + 16'h0001;
    done       = 1'b0;
    if (!adc_en) begin
      next_state = ST_IDLE;
      next_cnt   = 16'h0000;
    end else if (go_write) begin
      next_state = ST_FIRST;
      next_cnt   = 16'h0000;
    end else begin
      unique case (state)
        ST_IDLE: begin
          next_cnt = 16'h0000;
        end
        ST_FIRST: begin
          if (cnt == first_lim - 16'h0001) begin
            done       = 1'b1;
            next_cnt   = 16'h0000;
            next_state = repeat_conversion ? ST_REPEAT : ST_IDLE;
          end
        end
        ST_REPEAT: begin
          if (cnt == rep_lim - 16'h0001) begin
            done       = 1'b1;
            next_cnt   = 16'h0000;
            next_state = repeat_conversion ? ST_REPEAT : ST_IDLE;
          end
        end
      endcase
    end
  end

  // Sequencer registers; reset aborts any conversion
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      state <= ST_IDLE;
      cnt   <= 16'h0000;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result, alarms and interrupt

  logic [12:0] result;
  logic        hw_overflow_flag;
  logic [7:0]  lo_latch;
  logic [7:0]  result_upper_bits;
  logic        upper_alarm_flag;
  logic        lower_alarm_flag;
  logic        hi_evt;
  logic        lo_evt;
  logic        clr_hst;
  logic        clr_lst;

  // Threshold compare on single-ended samples only
  assign result_upper_bits = SAMPLE.data[12:5];
  assign hi_evt  = done & single_ended & (result_upper_bits > upper_threshold);
  assign lo_evt  = done & single_ended & (result_upper_bits < lower_threshold);
  assign clr_hst = wr & hit_bufalm & PWDATA[BA_HST];
  assign clr_lst = wr & hit_bufalm & PWDATA[BA_LST];

  // Result capture, lower-bit latch, sticky flags, interrupt pulse
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      result           <= '0;
      hw_overflow_flag <= 1'b0;
      lo_latch         <= 8'h00;
      upper_alarm_flag <= 1'b0;
      lower_alarm_flag <= 1'b0;
      IRQ              <= 1'b0;
    end else begin
      if (done) begin
        result           <= SAMPLE.data;
        hw_overflow_flag <= SAMPLE.ovf;
      end
      if (rd && hit_res_hi) begin
        lo_latch <= {result[4:0], 2'b00, hw_overflow_flag};
      end
      upper_alarm_flag <= hi_evt | (upper_alarm_flag & ~clr_hst);
      lower_alarm_flag <= lo_evt | (lower_alarm_flag & ~clr_lst);
      IRQ <= adc_en & (done | (hi_evt & upper_alarm_irq_enable)
                            | (lo_evt & lower_alarm_irq_enable));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup phase

  logic [7:0] rdata;

  assign rdata = hit_ctrl   ? {busy, ctrl} :
                 hit_bufalm ? {ref_high, upper_alarm_flag, lower_alarm_flag,
                               upper_alarm_irq_enable, lower_alarm_irq_enable,
                               buffer_mode_field} :
                 hit_res_hi ? result[12:5] :
                 hit_res_lo ? lo_latch :
                 hit_thr_hi ? upper_threshold :
                 hit_thr_lo ? lower_threshold :
                 hit_power  ? {6'h00, power_control_zero} : 8'h00;

  // Register read data during setup
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL && !PENABLE) begin
      PRDATA <= {24'h000000, rdata};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog controls

  adcc_ana_t next_ana;

  // Switch, reference and amplifier controls
  always_comb begin
    next_ana            = '0;
    next_ana.run        = (next_state != ST_IDLE);
    next_ana.restart    = go_write & adc_en;
    next_ana.switch_en  = mode_ok & code_ok;
    next_ana.diff       = ~single_ended;
    next_ana.buffered   = buffer_mode_field[0];
    next_ana.temp_sel   = temp_sel;
    next_ana.gnd_amp    = mode_ok & single_ended & (input_select == SE_GND);
    next_ana.offset_cal = mode_ok & ~single_ended & (input_select == DIFF_CAL);
    next_ana.chan       = input_select;
    next_ana.ref_int    = (ref_sel == REF_1V0) | (ref_sel == REF_2V0);
    next_ana.ref_2v0    = (ref_sel == REF_2V0);
    next_ana.ref_drive  = ctrl[CTRL_REF_DRIVE_OUT];
    next_ana.aux_amp_on = ~power_control_zero[PWR_AUX_OFF];
  end

  // Registered analog controls
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ANA <= '0;
    end else begin
      ANA <= next_ana;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  property p_go_starts;
    go_write && adc_en |=> state == ST_FIRST && cnt == 16'h0000;
  endproperty
  a_go_starts: assert property (p_go_starts) else $error("go did not start");

  property p_restart;
    go_write && adc_en && busy |=> cnt == 16'h0000 && !$past(done);
  endproperty
  a_restart: assert property (p_restart) else $error("restart failed");

  property p_go_zero;
    wr && hit_ctrl && !PWDATA[CTRL_GO] && busy && !done && adc_en |=> busy;
  endproperty
  a_go_zero: assert property (p_go_zero) else $error("writing 0 stopped");

  property p_single_stop;
    done && !repeat_conversion |=> state == ST_IDLE ##1 !done;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("no stop");

  property p_first_len;
    done && state == ST_FIRST |-> cnt == (temp_sel ? 16'(2 * FIRST_CYC - 1)
                                                   : 16'(FIRST_CYC - 1));
  endproperty
  a_first_len: assert property (p_first_len) else $error("first time wrong");

  property p_rep_len;
    done && state == ST_REPEAT |-> cnt == (temp_sel ? 16'(2 * REPEAT_CYC - 1)
                                                    : 16'(REPEAT_CYC - 1));
  endproperty
  a_rep_len: assert property (p_rep_len) else $error("repeat time wrong");

  property p_reserved_open;
    !(mode_ok && code_ok) |=> !ANA.switch_en;
  endproperty
  a_reserved_open: assert property (p_reserved_open) else $error("switch on");

  property p_hst_hw;
    $rose(upper_alarm_flag) |-> $past(done) && $past(single_ended);
  endproperty
  a_hst_hw: assert property (p_hst_hw) else $error("upper flag bad set");

  property p_lst_clear;
    clr_lst && !lo_evt |=> !lower_alarm_flag;
  endproperty
  a_lst_clear: assert property (p_lst_clear) else $error("lower flag stuck");

  property p_irq_off;
    !adc_en |=> !IRQ;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while off");

  property p_latch;
    rd && hit_res_hi |=> lo_latch[7:3] == result[4:0] || $past(done);
  endproperty
  a_latch: assert property (p_latch) else $error("latch mismatch");

  c_single: cover property (done && !repeat_conversion);
  c_repeat: cover property (done && state == ST_REPEAT);
  c_restart: cover property (go_write && busy);
  c_alarm: cover property (hi_evt && upper_alarm_irq_enable);

endmodule

// ### sim/adcc_core_model.sv
// Behavioural analog core and input switches feeding the control block
`timescale 1ns/10ps
module adcc_core_model
  import adcc_pkg::*;
(
  // Clock
  input  wire logic      CLK,
  // Controls from the block, value chosen by the bench
  input  wire adcc_ana_t ANA,
  input  wire adcc_smp_t VAL,
  // Sample toward the block
  output adcc_smp_t      SAMPLE
);
  logic [13:0] junk = 14'h1555;

  // Pattern that changes every cycle stands for a floating input
  always @(posedge CLK) begin
    junk <= ~junk;
  end

  // Open switches give no usable sample
  assign SAMPLE = ANA.switch_en ? VAL : junk;
endmodule

// ### sim/tb_top.sv
// Bench for the converter control block: APB sequences with expected values
`timescale 1ns/10ps
module tb_top
  import adcc_pkg::*;
;
  localparam int FC = 20;
  localparam int RC = 4;
  logic        clk     = 1'b0;
  logic        rstn    = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [13:0] paddr   = 14'h0000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  adcc_smp_t   sample;
  adcc_smp_t   val     = '0;
  adcc_ana_t   ana;
  logic [31:0] rd;
  logic [31:0] e;
  logic        err;
  logic        se;
  logic        df;
  logic        ok;
  int          n;
  int          bad_count = 0;
  int          checked   = 0;

  adcc_top #(.FIRST_CYC(FC), .REPEAT_CYC(RC)) u_dut (
    .CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SAMPLE(sample), .ANA(ana), .IRQ(irq)
  );

  adcc_core_model u_core (.CLK(clk), .ANA(ana), .VAL(val), .SAMPLE(sample));

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Wait states end only on pready; the watchdog bounds a hang
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [11:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask

  task automatic settle;
    repeat (2) @(posedge clk);
  endtask

  // Cycles until the interrupt pulse, or -1 if none within the limit
  task automatic wirq(input int lim);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (irq !== 1'b1 && n < lim);
    if (irq !== 1'b1) n = -1;
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // Reset values, refused access, amplifier power
    rdc(IDX_CTRL, 32'h00);
    rdc(IDX_BUFALM, 32'h80);
    rdc(IDX_THR_HI, 32'hff);
    rdc(IDX_THR_LO, 32'h00);
    rdc(IDX_POWER, 32'h03);
    chk(32'(ana.aux_amp_on), 32'h0);
    wr(12'h100, 32'h85);
    chk(32'(err), 32'h1);
    rdc(IDX_CTRL, 32'h00);
    wr(IDX_POWER, 32'h02);
    settle;
    chk(32'(ana.aux_amp_on), 32'h1);
    wr(IDX_POWER, 32'h03);
    // Reference select, drive kept off for the external pin
    for (int r = 0; r < 3; r++) begin
      wr(IDX_BUFALM, {24'h0, r[1], 7'h00});
      wr(IDX_CTRL, {24'h0, 1'b0, r[0], r != 0, 5'h00});
      settle;
      e = {29'h0, r != 0, r == 2, r != 0};
      chk({29'h0, ana.ref_int, ana.ref_2v0, ana.ref_drive}, e);
    end
    // Every buffer mode against every input code
    for (int m = 0; m < 8; m++) begin
      wr(IDX_BUFALM, 32'h80 | m);
      for (int c = 0; c < 16; c++) begin
        wr(IDX_CTRL, 32'(c));
        settle;
        se = (m < 2);
        df = (m == 4 || m == 5);
        ok = se ? (c < 8 || c == 12 || c == 14) : (df && (c < 11 || c == 15));
        chk(32'(ana.switch_en), 32'(ok));
        e = {27'h0, df, m[0], se && c == 14, se && c == 12, df && c == 15};
        if (se || df) begin
          chk({27'h0, ana.diff, ana.buffered, ana.temp_sel, ana.gnd_amp, ana.offset_cal}, e);
          chk(32'(ana.chan), 32'(c));
        end
      end
    end
    wr(IDX_BUFALM, 32'h80);
    // Single shot, result layout, stop afterwards
    val <= '{data: 13'h1a5c, ovf: 1'b1};
    wr(IDX_CTRL, 32'h83);
    wirq(3 * FC);
    chk(32'(n), 32'(FC - 1));
    rdc(IDX_CTRL, 32'h03);
    chk(32'(ana.run), 32'h0);
    rdc(IDX_RES_HI, 32'hd2);
    rdc(IDX_RES_LO, 32'he1);
    wr(IDX_RES_HI, 32'h00);
    rdc(IDX_RES_HI, 32'hd2);
    wirq(3 * FC);
    chk(32'(n), 32'hffff_ffff);
    // Restart while running; writing zero leaves it running
    wr(IDX_CTRL, 32'h83);
    rdc(IDX_CTRL, 32'h83);
    chk(32'(ana.run), 32'h1);
    wr(IDX_CTRL, 32'h03);
    wr(IDX_CTRL, 32'h83);
    wirq(3 * FC);
    chk(32'(n), 32'(FC - 1));
    // Temperature input doubles the time
    wr(IDX_CTRL, 32'h8e);
    wirq(4 * FC);
    chk(32'(n), 32'(2 * FC - 1));
    // Continuous updates, lower bits held from the upper read
    val <= '{data: 13'h0a55, ovf: 1'b0};
    wr(IDX_CTRL, 32'h93);
    wirq(3 * FC);
    chk(32'(n), 32'(FC - 1));
    wirq(2 * RC);
    chk(32'(n), 32'(RC - 1));
    val <= '{data: 13'h1234, ovf: 1'b0};
    rdc(IDX_RES_HI, 32'h52);
    rdc(IDX_RES_LO, 32'ha8);
    rdc(IDX_RES_HI, 32'h91);
    wr(IDX_CTRL, 32'h03);
    wirq(2 * RC);
    settle;
    rdc(IDX_CTRL, 32'h03);
    wirq(3 * FC);
    chk(32'(n), 32'hffff_ffff);
    // Threshold alarms, write-one clear, no alarms in differential
    wr(IDX_THR_HI, 32'h40);
    wr(IDX_THR_LO, 32'h20);
    wr(IDX_BUFALM, 32'h90);
    wr(IDX_CTRL, 32'h83);
    wirq(3 * FC);
    rdc(IDX_BUFALM, 32'hd0);
    wr(IDX_BUFALM, 32'hd0);
    rdc(IDX_BUFALM, 32'h90);
    val <= '{data: 13'h0200, ovf: 1'b0};
    wr(IDX_BUFALM, 32'h80);
    wr(IDX_CTRL, 32'h83);
    wirq(3 * FC);
    rdc(IDX_BUFALM, 32'ha0);
    wr(IDX_BUFALM, 32'ha0);
    rdc(IDX_BUFALM, 32'h80);
    wr(IDX_BUFALM, 32'h84);
    wr(IDX_CTRL, 32'h83);
    wirq(3 * FC);
    rdc(IDX_BUFALM, 32'h84);
    wr(IDX_BUFALM, 32'h80);
    // Disabled converter ignores go and raises nothing
    wr(IDX_POWER, 32'h01);
    wr(IDX_CTRL, 32'h83);
    wirq(3 * FC);
    chk(32'(n), 32'hffff_ffff);
    rdc(IDX_CTRL, 32'h03);
    wr(IDX_POWER, 32'h03);
    // Reset in mid conversion aborts it
    wr(IDX_CTRL, 32'h83);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    wirq(3 * FC);
    chk(32'(n), 32'hffff_ffff);
    rdc(IDX_CTRL, 32'h00);
    test_done;
  end
endmodule
